// [core/incr_exec_pkg.sv]
// Shared constants and carrier types for the increment and program-word-fetch execution block
package incr_exec_pkg;

	// Data path widths
	localparam int DATA_W = 8;
	localparam int WORD_W = 12;
	localparam int OPND_W = 5;
	localparam int FILE_DEPTH = 32;

	// Opcode matching: increment forms match the upper seven bits, the fetch form matches all twelve
	localparam int OPC_HI_LSB = 5;
	localparam logic [6:0] OPC_INC = 7'h15;
	localparam logic [6:0] OPC_INC_SKIP = 7'h1F;
	localparam logic [11:0] OPC_PROG_FETCH = 12'h041;

	// Fields of the fetched program word and of the page/mode register
	localparam int WORD_HI_LSB = 8;
	localparam int MODE_LO_MSB = 3;
	localparam logic [3:0] MODE_HI_CLEAR = 4'h0;

	// Reset values
	localparam logic [7:0] ACC_RST = 8'h00;
	localparam logic [7:0] MODE_RST = 8'h00;
	localparam logic ZFLAG_RST = 1'b0;

	// Instruction cycle counts reported on completion
	localparam logic [1:0] CYC_PLAIN = 2'h1;
	localparam logic [1:0] CYC_SKIPPED = 2'h2;

	// Increment step
	localparam logic [7:0] INC_STEP = 8'h01;
	localparam logic [7:0] ZERO_BYTE = 8'h00;

	// Instruction handed over by the decoder
	typedef struct packed {
		logic valid;
		logic [11:0] word;
	} instr_t;

	// A write into the file register store
	typedef struct packed {
		logic en;
		logic [4:0] addr;
		logic [7:0] data;
	} file_wr_t;

	// Which instruction is in flight or just finished
	typedef enum logic [1:0] {
		OP_NONE,
		OP_INC,
		OP_INC_SKIP,
		OP_FETCH
	} op_kind_t;

endpackage

// [core/file_reg_store.sv]
// File register store: one write port, one read port with registered read data
`timescale 1ns/1ps
`default_nettype none
module file_reg_store #(
	parameter int DEPTH = 32,
	parameter int ADDR_W = 5,
	parameter int WIDTH = 8
) (
	// Clock
	input wire logic core_clk,
	// Write port
	input wire logic wr_en,
	input wire logic [ADDR_W-1:0] wr_addr,
	input wire logic [WIDTH-1:0] wr_data,
	// Read port
	input wire logic [ADDR_W-1:0] rd_addr,
	output logic [WIDTH-1:0] rd_data
);

	logic [WIDTH-1:0] mem [DEPTH];

	// Elaboration-time refusal of a depth that the address cannot reach
	if (DEPTH > (1 << ADDR_W)) begin : g_depth_check
		$error("file_reg_store: DEPTH exceeds address range");
	end

	// Storage has no reset; contents are defined by software before use
	always_ff @(posedge core_clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		rd_data <= mem[rd_addr];
	end

endmodule
`default_nettype wire

// [core/incr_skip_and_progmem_read_exec.sv]
// Execution of the two increment instructions and the program-word-fetch instruction
`timescale 1ns/1ps
`default_nettype none
module incr_skip_and_progmem_read_exec
	import incr_exec_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Instruction from the decoder
	input wire instr_t instr,
	output logic instr_ready,
	// Direct load of a file register by the rest of the core
	input wire file_wr_t file_load,
	// Direct load of accumulator and page/mode register
	input wire logic acc_load_en,
	input wire logic [7:0] acc_load_data,
	input wire logic mode_load_en,
	input wire logic [7:0] mode_load_data,
	// Program memory read port
	output logic prog_rd_en,
	output logic [11:0] prog_addr,
	input wire logic [11:0] prog_rdata,
	// Architectural state
	output logic [7:0] acc,
	output logic [7:0] mode,
	output logic zero_flag,
	// Completion
	output file_wr_t file_wb,
	output logic instr_done,
	output logic skip_next,
	output logic [1:0] instr_cycles
);

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_INC,
		ST_FETCH
	} state_t;

	state_t state_reg, state_next;
	op_kind_t op_reg, op_next;
	logic [4:0] opnd_reg, opnd_next;
	logic ready_reg, ready_next;
	logic rd_en_reg, rd_en_next;
	logic [11:0] paddr_reg, paddr_next;
	logic [7:0] acc_reg, acc_next;
	logic [7:0] mode_reg, mode_next;
	logic z_reg, z_next;
	file_wr_t wb_reg, wb_next;
	logic done_reg, done_next;
	logic skip_reg, skip_next_v;
	logic [1:0] cyc_reg, cyc_next;

	logic [7:0] file_rdata;
	logic [7:0] inc_sum;
	logic take;
	logic is_inc, is_inc_skip, is_fetch;
	logic store_we;
	logic [4:0] store_waddr;
	logic [7:0] store_wdata;

	assign take = instr.valid && ready_reg;
	assign is_inc = instr.word[11:OPC_HI_LSB] == OPC_INC;
	assign is_inc_skip = instr.word[11:OPC_HI_LSB] == OPC_INC_SKIP;
	assign is_fetch = instr.word == OPC_PROG_FETCH;
	assign inc_sum = file_rdata + INC_STEP;

	// Writeback from an increment has priority over a direct load in the same cycle
	assign store_we = wb_next.en || (file_load.en && state_reg == ST_IDLE);
	assign store_waddr = wb_next.en ? wb_next.addr : file_load.addr;
	assign store_wdata = wb_next.en ? wb_next.data : file_load.data;

	file_reg_store #(
		.DEPTH(FILE_DEPTH),
		.ADDR_W(OPND_W),
		.WIDTH(DATA_W)
	) u_store (
		.core_clk(core_clk),
		.wr_en(store_we),
		.wr_addr(store_waddr),
		.wr_data(store_wdata),
		.rd_addr(instr.word[OPND_W-1:0]),
		.rd_data(file_rdata)
	);

	always_comb begin
		state_next = state_reg;
		op_next = op_reg;
		opnd_next = opnd_reg;
		rd_en_next = 1'b0;
		paddr_next = paddr_reg;
		acc_next = acc_load_en ? acc_load_data : acc_reg;
		mode_next = mode_load_en ? mode_load_data : mode_reg;
		z_next = z_reg;
		wb_next = '0;
		done_next = 1'b0;
		skip_next_v = 1'b0;
		cyc_next = cyc_reg;
		case (state_reg)
			ST_IDLE: begin
				if (take && (is_inc || is_inc_skip)) begin
					op_next = is_inc ? OP_INC : OP_INC_SKIP;
					opnd_next = instr.word[OPND_W-1:0];
					state_next = ST_INC;
				end else if (take && is_fetch) begin
					op_next = OP_FETCH;
					rd_en_next = 1'b1;
					paddr_next = {mode_reg[MODE_LO_MSB:0], acc_reg};
					state_next = ST_FETCH;
				end
			end
			ST_INC: begin
				wb_next.en = 1'b1;
				wb_next.addr = opnd_reg;
				wb_next.data = inc_sum;
				done_next = 1'b1;
				cyc_next = CYC_PLAIN;
				if (op_reg == OP_INC) begin
					z_next = inc_sum == ZERO_BYTE;
				end else if (inc_sum == ZERO_BYTE) begin
					skip_next_v = 1'b1;
					cyc_next = CYC_SKIPPED;
				end
				state_next = ST_IDLE;
			end
			ST_FETCH: begin
				acc_next = prog_rdata[WORD_HI_LSB-1:0];
				mode_next = {MODE_HI_CLEAR, prog_rdata[WORD_W-1:WORD_HI_LSB]};
				done_next = 1'b1;
				cyc_next = CYC_PLAIN;
				state_next = ST_IDLE;
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
		ready_next = state_next == ST_IDLE;
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state_reg <= ST_IDLE;
			op_reg <= OP_NONE;
			opnd_reg <= 5'h00;
			ready_reg <= 1'b0;
			rd_en_reg <= 1'b0;
			paddr_reg <= 12'h000;
			acc_reg <= ACC_RST;
			mode_reg <= MODE_RST;
			z_reg <= ZFLAG_RST;
			wb_reg <= '0;
			done_reg <= 1'b0;
			skip_reg <= 1'b0;
			cyc_reg <= 2'h0;
		end else begin
			state_reg <= state_next;
			op_reg <= op_next;
			opnd_reg <= opnd_next;
			ready_reg <= ready_next;
			rd_en_reg <= rd_en_next;
			paddr_reg <= paddr_next;
			acc_reg <= acc_next;
			mode_reg <= mode_next;
			z_reg <= z_next;
			wb_reg <= wb_next;
			done_reg <= done_next;
			skip_reg <= skip_next_v;
			cyc_reg <= cyc_next;
		end
	end

	assign instr_ready = ready_reg;
	assign prog_rd_en = rd_en_reg;
	assign prog_addr = paddr_reg;
	assign acc = acc_reg;
	assign mode = mode_reg;
	assign zero_flag = z_reg;
	assign file_wb = wb_reg;
	assign instr_done = done_reg;
	assign skip_next = skip_reg;
	assign instr_cycles = cyc_reg;

	// Checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	logic [7:0] rdata_q;
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			rdata_q <= 8'h00;
		end else begin
			rdata_q <= file_rdata;
		end
	end

	chk_inc_writeback: assert property (
		instr_done && op_reg == OP_INC |-> file_wb.en && file_wb.data == rdata_q + INC_STEP
	) else $error("add-one wrote wrong value");

	chk_inc_zero_flag: assert property (
		instr_done && op_reg == OP_INC |-> zero_flag == (file_wb.data == ZERO_BYTE)
	) else $error("add-one zero flag wrong");

	chk_skip_decision: assert property (
		instr_done && op_reg == OP_INC_SKIP |-> skip_next == (file_wb.data == ZERO_BYTE) && $stable(zero_flag)
	) else $error("add-one-and-skip skip or flag wrong");

	chk_skip_cycles: assert property (
		instr_done && op_reg == OP_INC_SKIP |-> instr_cycles == (skip_next ? CYC_SKIPPED : CYC_PLAIN)
	) else $error("add-one-and-skip cycle count wrong");

	chk_fetch_address: assert property (
		take && is_fetch && !acc_load_en && !mode_load_en |=> prog_rd_en && prog_addr == {$past(mode_reg[3:0]), $past(acc_reg)}
	) else $error("fetch address wrong");

	chk_fetch_result: assert property (
		prog_rd_en |=> instr_done && acc == $past(prog_rdata[7:0]) && mode[3:0] == $past(prog_rdata[11:8])
	) else $error("fetch result placement wrong");

	chk_fetch_mode_high: assert property (
		instr_done && op_reg == OP_FETCH |-> mode[7:4] == MODE_HI_CLEAR
	) else $error("fetch left mode high bits set");

	chk_fetch_no_flags: assert property (
		take && is_fetch |=> ##1 instr_done && instr_cycles == CYC_PLAIN && $stable(zero_flag) && !skip_next
	) else $error("fetch changed flags or took wrong cycles");

	chk_operand_address: assert property (
		take && (is_inc || is_inc_skip) |-> ##2 file_wb.en && file_wb.addr == $past(instr.word[4:0], 2)
	) else $error("increment used wrong operand register");

	cov_inc_wrap: cover property (instr_done && op_reg == OP_INC && zero_flag);
	cov_skip_taken: cover property (instr_done && skip_next);
	cov_skip_not_taken: cover property (instr_done && op_reg == OP_INC_SKIP && !skip_next);
	cov_fetch_done: cover property (instr_done && op_reg == OP_FETCH);

endmodule
`default_nettype wire

// [verification/test_incr_skip_and_progmem_read_exec.sv]
// Self-checking testbench for the increment and program-word-fetch execution block
`timescale 1ns/1ps
`default_nettype none
module test_incr_skip_and_progmem_read_exec;
	import incr_exec_pkg::*;

	logic core_clk = 1'b0;
	logic rst = 1'b1;
	instr_t instr = '0;
	logic instr_ready;
	file_wr_t file_load = '0;
	logic acc_load_en = 1'b0;
	logic [7:0] acc_load_data = 8'h00;
	logic mode_load_en = 1'b0;
	logic [7:0] mode_load_data = 8'h00;
	logic prog_rd_en;
	logic [11:0] prog_addr;
	logic [11:0] prog_rdata = 12'h000;
	logic [7:0] acc;
	logic [7:0] mode;
	logic zero_flag;
	file_wr_t file_wb;
	logic instr_done;
	logic skip_next;
	logic [1:0] instr_cycles;
	int errors = 0;
	int check_count = 0;
	logic rd_seen;
	logic [11:0] addr_seen;

	always #12.5 core_clk = ~core_clk;

	incr_skip_and_progmem_read_exec uut (
		.core_clk(core_clk), .rst(rst), .instr(instr), .instr_ready(instr_ready),
		.file_load(file_load), .acc_load_en(acc_load_en), .acc_load_data(acc_load_data),
		.mode_load_en(mode_load_en), .mode_load_data(mode_load_data), .prog_rd_en(prog_rd_en),
		.prog_addr(prog_addr), .prog_rdata(prog_rdata), .acc(acc), .mode(mode), .zero_flag(zero_flag),
		.file_wb(file_wb), .instr_done(instr_done), .skip_next(skip_next), .instr_cycles(instr_cycles)
	);

	task automatic wrap_up();
		$display("Comparisons %0d, mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] t=%0t seen=%0h exp=%0h", $time, seen, exp);
		end
	endtask

	// Present one instruction and stop at the cycle where it completes
	task automatic issue(input logic [11:0] w);
		int n;
		n = 0;
		while (instr_ready !== 1'b1 && n < 20) begin
			@(posedge core_clk);
			#1;
			n++;
		end
		if (n == 20) begin
			errors++;
			wrap_up();
		end
		@(posedge core_clk);
		instr <= '{valid: 1'b1, word: w};
		@(posedge core_clk);
		instr <= '{valid: 1'b0, word: w};
		#1;
		rd_seen = prog_rd_en;
		addr_seen = prog_addr;
		@(posedge core_clk);
		#1;
		check(instr_done, 1'b1);
	endtask

	task automatic load_file(input logic [4:0] a, input logic [7:0] d);
		@(posedge core_clk);
		file_load <= '{en: 1'b1, addr: a, data: d};
		@(posedge core_clk);
		file_load <= '{en: 1'b0, addr: a, data: d};
	endtask

	task automatic sc_inc();
		load_file(5'h18, 8'h41);
		issue({OPC_INC, 5'h18});
		check(file_wb, {1'b1, 5'h18, 8'h42});
		check(zero_flag, 1'b0);
		check(instr_cycles, CYC_PLAIN);
		load_file(5'h1F, 8'hFF);
		issue({OPC_INC, 5'h1F});
		check(file_wb, {1'b1, 5'h1F, 8'h00});
		check(zero_flag, 1'b1);
		issue({OPC_INC, 5'h1F});
		check(file_wb, {1'b1, 5'h1F, 8'h01});
		check(zero_flag, 1'b0);
	endtask

	task automatic sc_skip();
		load_file(5'h03, 8'hFF);
		issue({OPC_INC_SKIP, 5'h03});
		check(file_wb, {1'b1, 5'h03, 8'h00});
		check(skip_next, 1'b1);
		check(instr_cycles, CYC_SKIPPED);
		check(zero_flag, 1'b0);
		load_file(5'h1F, 8'hFF);
		issue({OPC_INC, 5'h1F});
		load_file(5'h04, 8'h07);
		issue({OPC_INC_SKIP, 5'h04});
		check(file_wb, {1'b1, 5'h04, 8'h08});
		check(skip_next, 1'b0);
		check(instr_cycles, CYC_PLAIN);
		check(zero_flag, 1'b1);
	endtask

	task automatic sc_fetch();
		@(posedge core_clk);
		acc_load_en <= 1'b1;
		acc_load_data <= 8'h80;
		mode_load_en <= 1'b1;
		mode_load_data <= 8'hF3;
		prog_rdata <= 12'hA5C;
		@(posedge core_clk);
		acc_load_en <= 1'b0;
		mode_load_en <= 1'b0;
		issue(OPC_PROG_FETCH);
		check(rd_seen, 1'b1);
		check(addr_seen, 12'h380);
		check(acc, 8'h5C);
		check(mode, 8'h0A);
		check(instr_cycles, CYC_PLAIN);
		check(zero_flag, 1'b1);
		check(file_wb.en, 1'b0);
	endtask

	initial begin
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		#1;
		check(instr_ready, 1'b1);
		check({acc, mode}, {ACC_RST, MODE_RST});
		check(zero_flag, ZFLAG_RST);
		sc_inc();
		sc_skip();
		sc_fetch();
		wrap_up();
	end
endmodule
`default_nettype wire
